// [src/sfd_consts.svh]
// sfd_consts.svh: offsets, field positions, reset values and table bytes for sector-map discovery
//
// Behaviour
// - The map index is the uniform/hybrid bit, then the split bit, then the top/bottom bit, MSb first.
// - Select bit 0 gives a hybrid map with 4KB parameter sectors; 1 gives the uniform map, index 04h (the code gives no valid map for 03h and 05h-07h).
// - In hybrid mode, top/bottom 0 puts the 4KB sectors low and 1 puts them high.
// - In hybrid mode, split 0 keeps the 4KB sectors together and 1 splits them bottom and top.
// - Index 00h is hybrid with 4KB sectors at the bottom and the rest 256KB.
// - Index 01h is hybrid with 4KB sectors at the top and the rest 256KB.
// - Index 02h is hybrid with 4KB sectors split top and bottom and the rest 256KB.
// - Detect descriptor 1 gives instruction 65h at 00800004h with mask 0000_1000b (bit 3).
// - Detect descriptor 2 uses mask 0100_0000b, isolating bit 6 as the split indicator.
// - Descriptors encode address length 11b and latency 1111b, both variable.
// - A descriptor that is not the last reports bit 1 as 0 and bit 0 as 0.
// - The second octal DDR command sequence is 5 bytes: 71h, 80h, 00h, 06h, then 43h.
// - Detect descriptor 2 gives register address 00800002h for the split bit.
// - Detect descriptor 3 uses mask 0000_0100b (bit 2) and marks itself as the last.
`ifndef SFD_CONSTS_SVH
`define SFD_CONSTS_SVH

// register addresses on the plain port
`define SFD_ADDR_CFG_ONE     32'h0080_0002
`define SFD_ADDR_CFG_THREE   32'h0080_0004
`define SFD_ADDR_TABLE_FIRST 32'h0000_01e4
`define SFD_ADDR_TABLE_LAST  32'h0000_0203

// field positions inside the volatile configuration registers
`define SFD_BIT_UNIFORM      3
`define SFD_BIT_SPLIT        6
`define SFD_BIT_TOP          2

// reset values of the volatile configuration registers
`define SFD_RST_CFG_ONE      8'h00
`define SFD_RST_CFG_THREE    8'h00

// detection descriptor fields
`define SFD_DET_INSTR        8'h65
`define SFD_DET_ADDR_LEN     2'h3
`define SFD_DET_RFU_HI       2'h3
`define SFD_DET_LATENCY      4'hf
`define SFD_DET_RFU_LO       6'h3f
`define SFD_DET_CMD_DESC     1'h0
`define SFD_MASK_UNIFORM     8'h08
`define SFD_MASK_SPLIT       8'h40
`define SFD_MASK_TOP         8'h04

// second octal DDR command sequence
`define SFD_SEQ2_LEN         8'h05
`define SFD_SEQ2_B1          8'h71
`define SFD_SEQ2_B2          8'h80
`define SFD_SEQ2_B3          8'h00
`define SFD_SEQ2_B4          8'h06
`define SFD_SEQ2_B5          8'h43
`define SFD_SEQ2_PAD         8'h00

// supported map indexes
`define SFD_IDX_BOTTOM       3'h0
`define SFD_IDX_TOP          3'h1
`define SFD_IDX_SPLIT        3'h2
`define SFD_IDX_UNIFORM      3'h4

// read data for an unmapped address
`define SFD_RD_UNMAPPED      8'h00

`endif

// [src/sfd_pkg.sv]
// sfd_pkg.sv: types shared by the sector-map discovery block
package sfd_pkg;

  typedef struct packed {
    logic [31:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } sfd_req_t;

  typedef struct packed {
    logic [2:0] index;
    logic       uniform;
    logic       param_top;
    logic       param_split;
    logic       param_bottom;
    logic       valid;
  } sfd_map_t;

endpackage : sfd_pkg

// [src/sfd_discovery.sv]
// sfd_discovery.sv: volatile config bits, sector-map index and discovery table read port
//
// Added by the designer: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "sfd_consts.svh"

module sfd_discovery
  import sfd_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  input  wire logic [31:0] addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output var  logic [7:0]  rdata_o,
  output var  sfd_map_t    map_o
);

  // ****************************************************************
  // descriptor builders
  // ****************************************************************
  // variable address length and latency
  function automatic logic [31:0] det_word(input logic [7:0] mask, input logic last);
    det_word = {mask, `SFD_DET_ADDR_LEN, `SFD_DET_RFU_HI, `SFD_DET_LATENCY,
                `SFD_DET_INSTR, `SFD_DET_RFU_LO, `SFD_DET_CMD_DESC, last};
  endfunction : det_word

  // table as dwords, lowest byte address in the low byte
  localparam int NWORDS = 8;
  logic [31:0] table_w [NWORDS];
  always_comb begin
    table_w[0] = {`SFD_SEQ2_LEN, `SFD_SEQ2_B1, `SFD_SEQ2_B2, `SFD_SEQ2_B3};
    table_w[1] = {`SFD_SEQ2_B4, `SFD_SEQ2_B5, `SFD_SEQ2_PAD, `SFD_SEQ2_PAD};
    table_w[2] = det_word(`SFD_MASK_UNIFORM, 1'b0);
    table_w[3] = `SFD_ADDR_CFG_THREE;
    table_w[4] = det_word(`SFD_MASK_SPLIT, 1'b0);
    table_w[5] = `SFD_ADDR_CFG_ONE;
    table_w[6] = det_word(`SFD_MASK_TOP, 1'b1);
    table_w[7] = `SFD_ADDR_CFG_ONE;
  end

  // ****************************************************************
  // volatile configuration registers
  // ****************************************************************
  logic [7:0] cfg_one_reg;
  logic [7:0] cfg_three_reg;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_one_reg <= `SFD_RST_CFG_ONE;
    end else if (wr_i && addr_i == `SFD_ADDR_CFG_ONE) begin
      cfg_one_reg <= wdata_i;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_three_reg <= `SFD_RST_CFG_THREE;
    end else if (wr_i && addr_i == `SFD_ADDR_CFG_THREE) begin
      cfg_three_reg <= wdata_i;
    end
  end

  // ****************************************************************
  // read port: data in the cycle after the strobe only
  // ****************************************************************
  logic [7:0]  rdata_next;
  logic [31:0] toff;
  logic [31:0] tword;
  always_comb begin
    toff       = addr_i - `SFD_ADDR_TABLE_FIRST;
    tword      = table_w[toff[4:2]];
    rdata_next = `SFD_RD_UNMAPPED;
    if (rd_i) begin
      if (addr_i == `SFD_ADDR_CFG_ONE) begin
        rdata_next = cfg_one_reg;
      end else if (addr_i == `SFD_ADDR_CFG_THREE) begin
        rdata_next = cfg_three_reg;
      end else if (addr_i >= `SFD_ADDR_TABLE_FIRST && addr_i <= `SFD_ADDR_TABLE_LAST) begin
        rdata_next = tword[toff[1:0]*8 +: 8];
      end
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= `SFD_RD_UNMAPPED;
    end else begin
      rdata_o <= rdata_next;
    end
  end

  // ****************************************************************
  // sector map selection
  // ****************************************************************
  sfd_map_t map_next;
  always_comb begin
    map_next.index = {cfg_three_reg[`SFD_BIT_UNIFORM], cfg_one_reg[`SFD_BIT_SPLIT],
                      cfg_one_reg[`SFD_BIT_TOP]};
    map_next.uniform      = map_next.index == `SFD_IDX_UNIFORM;
    map_next.param_top    = map_next.index == `SFD_IDX_TOP;
    map_next.param_bottom = map_next.index == `SFD_IDX_BOTTOM;
    map_next.param_split  = map_next.index == `SFD_IDX_SPLIT;
    map_next.valid = map_next.uniform | map_next.param_top | map_next.param_bottom
                   | map_next.param_split;
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      map_o <= '0;
    end else begin
      map_o <= map_next;
    end
  end

endmodule : sfd_discovery
`default_nettype wire

// [verification/sfd_discovery_properties.sv]
// port checker for the discovery block
`timescale 1ns/1ps
`default_nettype none
module sfd_discovery_properties
  import sfd_pkg::*;
(
  input wire logic        mclk_i,
  input wire logic        rst_i,
  input wire logic [31:0] addr_i,
  input wire logic [7:0]  wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [7:0]  rdata_o,
  input wire sfd_map_t    map_o
);
  // ****
  // map and read port properties
  // ****
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  a_idle_rdata: assert property (!rd_i |=> rdata_o == 8'h00)
    else $error("rdata not idle");
  a_clear_uniform: assert property (wr_i && addr_i == 32'h0080_0004 && !wdata_i[3]
    |-> ##2 !map_o.uniform)
    else $error("uniform kept");
  a_uniform_index: assert property (map_o.uniform |-> map_o.index == 3'h4)
    else $error("uniform index");
  a_index_concat: assert property (map_o.valid
    |-> map_o.index == {map_o.uniform, map_o.param_split, map_o.param_top})
    else $error("index order");
  a_bottom_map: assert property (map_o.param_bottom |-> map_o.index == 3'h0)
    else $error("bottom map");
  a_top_map: assert property (map_o.param_top |-> map_o.index == 3'h1)
    else $error("top map");
  a_split_map: assert property (map_o.param_split |-> map_o.index == 3'h2)
    else $error("split map");
  a_invalid_map: assert property (!map_o.valid |-> map_o[4:1] == 4'h0)
    else $error("invalid map flags");
  a_detect_instr: assert property (rd_i && addr_i == 32'h0000_01ed |=> rdata_o == 8'h65)
    else $error("detect instruction byte");
  a_split_mask: assert property (rd_i && addr_i == 32'h0000_01f7 |=> rdata_o == 8'h40)
    else $error("split mask byte");
  a_seq_length: assert property (rd_i && addr_i == 32'h0000_01e7 |=> rdata_o == 8'h05)
    else $error("sequence length byte");
  a_not_last: assert property (rd_i && addr_i == 32'h0000_01f4 |=> rdata_o == 8'hfc)
    else $error("descriptor end flag");
  a_split_addr: assert property (rd_i && addr_i == 32'h0000_01f8 |=> rdata_o == 8'h02)
    else $error("split address byte");
  a_last_desc: assert property (rd_i && addr_i == 32'h0000_01fc |=> rdata_o == 8'hfd)
    else $error("last descriptor byte");
  c_uniform: cover property (map_o.uniform);
  c_top: cover property (map_o.param_top);
  c_split: cover property (map_o.param_split);
  c_invalid: cover property (!map_o.valid);
endmodule : sfd_discovery_properties
bind sfd_discovery sfd_discovery_properties i_props (
  .mclk_i  (mclk_i),
  .rst_i   (rst_i),
  .addr_i  (addr_i),
  .wdata_i (wdata_i),
  .wr_i    (wr_i),
  .rd_i    (rd_i),
  .rdata_o (rdata_o),
  .map_o   (map_o)
);
`default_nettype wire

// [verification/sfd_host_model.sv]
// host controller model driving the plain register port
`timescale 1ns/1ps
`default_nettype none
module sfd_host_model (
  input  wire logic        mclk_i,
  input  wire logic [7:0]  rdata_i,
  output var  logic [31:0] addr_o,
  output var  logic [7:0]  wdata_o,
  output var  logic        wr_o,
  output var  logic        rd_o
);
  initial begin
    addr_o  = 32'h0;
    wdata_o = 8'h00;
    wr_o    = 1'b0;
    rd_o    = 1'b0;
  end
  task automatic host_write(input logic [31:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    addr_o  <= a;
    wdata_o <= d;
    wr_o    <= 1'b1;
    @(posedge mclk_i);
    wr_o    <= 1'b0;
    addr_o  <= ~a;
    wdata_o <= ~d;
  endtask : host_write
  // byte reads, widths left to the device
  task automatic host_read(input logic [31:0] a, output logic [7:0] d);
    @(posedge mclk_i);
    addr_o <= a;
    rd_o   <= 1'b1;
    @(posedge mclk_i);
    rd_o   <= 1'b0;
    addr_o <= ~a;
    #1 d = rdata_i;
  endtask : host_read
endmodule : sfd_host_model
`default_nettype wire

// [verification/test_sfd_discovery.sv]
// self-checking bench for the discovery block
`timescale 1ns/1ps
`default_nettype none
module test_sfd_discovery import sfd_pkg::*;;
  logic        mclk_i = 1'b0;
  logic        rst_i  = 1'b1;
  logic [31:0] addr;
  logic [7:0]  wdata, rdata, d;
  logic        wr, rd;
  sfd_map_t    map;
  int          error_cnt = 0;
  int          checks = 0;
  logic [255:0] tbl = 256'h0080_0002_04ff_65fd_0080_0002_40ff_65fc_0080_0004_08ff_65fc_0643_0000_0571_8000;
  always #12.5 mclk_i = ~mclk_i;
  sfd_discovery i_dut (.mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .map_o(map));
  sfd_host_model i_host (.mclk_i(mclk_i), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
    .wr_o(wr), .rd_o(rd));
  // ****
  // compare, scenarios and verdict
  // ****
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask : cmp8
  task automatic t_table;
    i_host.host_write(32'h1e4, 8'hff);
    for (int i = 0; i < 32; i++) begin
      i_host.host_read(32'h1e4 + 32'(i), d);
      cmp8(d, tbl[8*i +: 8]);
    end
    i_host.host_read(32'h300, d);
    cmp8(d, 8'h00);
  endtask : t_table
  task automatic t_map(input logic [7:0] c3, c1, exp, msk);
    i_host.host_write(32'h0080_0004, c3);
    i_host.host_write(32'h0080_0002, c1);
    i_host.host_read(32'h0080_0002, d);
    cmp8(d, c1);
    i_host.host_read(32'h0080_0004, d);
    cmp8(d, c3);
    cmp8(map & msk, exp);
  endtask : t_map
  // cfg_three_reg returns to its reset value on a mid-run reset
  task automatic t_reset;
    i_host.host_write(32'h0080_0004, 8'h08);
    @(posedge mclk_i);
    rst_i <= 1'b1;
    #1 cmp8(map, 8'h00);
    repeat (2) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(posedge mclk_i);
    #1 cmp8(map, 8'h03);
    i_host.host_read(32'h0080_0004, d);
    cmp8(d, 8'h00);
  endtask : t_reset
  task automatic complete_run;
    if (error_cnt == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : complete_run
  initial begin
    repeat (2) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(posedge mclk_i);
    #1 cmp8(map, 8'h03);
    t_table();
    t_map(8'h00, 8'h04, 8'h29, 8'hff);
    t_map(8'h00, 8'h40, 8'h45, 8'hff);
    t_map(8'h08, 8'h00, 8'h91, 8'hff);
    t_map(8'h08, 8'h44, 8'h00, 8'h1f);
    t_map(8'h00, 8'h00, 8'h03, 8'hff);
    t_reset();
    complete_run();
  end
endmodule : test_sfd_discovery
`default_nettype wire
